// file: logic/code_lock_pkg.sv
// constants for the program memory lock block
// ==========================================================
// Summary of operation
// - no lock bit programmed: verify read-back of internal code allowed
// - bit one programmed: external table reads of internal code blocked
// - bit one programmed: all further programming of code memory refused
// - bits one and two: level-one limits plus verify read-back disabled
// - all three bits: lower limits plus external code execution blocked
// - all three bits: internal data RAM closed to outside access
// - three read-only signature bytes identify part type and maker
// - image lock byte: bits 0, 1, 3 are active-low lock bits
package code_lock_pkg;
    // ==========================================================
    // image layout
    localparam logic [15:0] CODE_TOP_ADDR  = 16'h7FFF;
    localparam logic [15:0] LOCK_BYTE_ADDR = 16'h8020;
    localparam int          LOCK_ONE_POS   = 0;
    localparam int          LOCK_TWO_POS   = 1;
    localparam int          LOCK_THREE_POS = 3;
    // ==========================================================
    // signature bytes, values arbitrary
    localparam logic [7:0]  SIG_MAKER      = 8'h5A;
    localparam logic [7:0]  SIG_FAMILY     = 8'h3C;
    localparam logic [7:0]  SIG_PART       = 8'h01;
    localparam logic [1:0]  SIG_IDX_MAKER  = 2'h0;
    localparam logic [1:0]  SIG_IDX_FAMILY = 2'h1;
    localparam logic [1:0]  SIG_IDX_PART   = 2'h2;

    typedef enum logic [1:0] {
        LVL_OPEN   = 2'h0,
        LVL_ONE    = 2'h1,
        LVL_TWO    = 2'h2,
        LVL_THREE  = 2'h3
    } lock_level_t;

    typedef enum logic [1:0] {
        CAP_IDLE   = 2'h0,
        CAP_SETTLE = 2'h1,
        CAP_DONE   = 2'h2
    } capture_state_t;
endpackage

// file: logic/code_memory_security_lock.sv
// program memory lock decode and access gating
`timescale 1ns/1ps
module code_memory_security_lock (
    input  wire logic        core_clk,         // core clock 200 MHz
    input  wire logic        rst_n,            // async reset, active low
    input  wire logic [7:0]  lockByte,         // nonvolatile lock byte
    input  wire logic        tableReadReq,     // code table read request
    input  wire logic        tableReadFromExt, // issuing code is external
    input  wire logic        tableReadInt,     // target is internal code
    input  wire logic        extFetchReq,      // external code fetch
    input  wire logic        progReq,          // programming pulse request
    input  wire logic        verifyReq,        // verify read-back request
    input  wire logic        ramExtReq,        // outside access to data RAM
    input  wire logic        sigReq,           // signature read request
    input  wire logic [1:0]  sigIdx,           // signature byte index
    output logic             tableReadOk,      // table read granted
    output logic             extFetchOk,       // external fetch granted
    output logic             progOk,           // programming granted
    output logic             verifyOk,         // verify granted
    output logic             ramExtOk,         // ram access granted
    output logic [7:0]       sigData,          // signature byte
    output logic             sigValid,         // signature byte valid
    output logic [1:0]       lockLevel,        // decoded level
    output logic             levelValid        // level captured
);
    // ==========================================================
    // level capture
    code_lock_pkg::capture_state_t capState_reg, capState_next;
    code_lock_pkg::lock_level_t    level_reg, level_next;
    logic [7:0] sync1_reg, sync2_reg, sync3_reg;
    logic [2:0] syncFill_reg, syncFill_next;

    function automatic code_lock_pkg::lock_level_t decode_level(
        input logic [7:0] b
    );
        logic one;
        logic two;
        logic three;
        one   = ~b[code_lock_pkg::LOCK_ONE_POS];
        two   = ~b[code_lock_pkg::LOCK_TWO_POS];
        three = ~b[code_lock_pkg::LOCK_THREE_POS];
        // other combinations are undefined; round down to the cumulative set
        if (one && two && three)
            return code_lock_pkg::LVL_THREE;
        else if (one && two)
            return code_lock_pkg::LVL_TWO;
        else if (one)
            return code_lock_pkg::LVL_ONE;
        else
            return code_lock_pkg::LVL_OPEN;
    endfunction

    always_comb begin
        capState_next = capState_reg;
        level_next    = level_reg;
        // one more stage holds a pin sample after every edge
        syncFill_next = {syncFill_reg[1:0], 1'b1};
        case (capState_reg)
            code_lock_pkg::CAP_IDLE:
                capState_next = code_lock_pkg::CAP_SETTLE;
            code_lock_pkg::CAP_SETTLE: begin
                // the stages reset to all-programmed, which is no pin
                // sample; wait until stage three holds a real one
                if (syncFill_reg[2] && sync2_reg == sync3_reg) begin
                    level_next    = decode_level(sync3_reg);
                    capState_next = code_lock_pkg::CAP_DONE;
                end
            end
            code_lock_pkg::CAP_DONE:   capState_next = code_lock_pkg::CAP_DONE;
            default:                   capState_next = code_lock_pkg::CAP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            capState_reg <= code_lock_pkg::CAP_IDLE;
            // most restrictive until the real level is known
            level_reg    <= code_lock_pkg::LVL_THREE;
            sync1_reg    <= 8'h00;
            sync2_reg    <= 8'h00;
            sync3_reg    <= 8'h00;
            syncFill_reg <= 3'h0;
        end else begin
            capState_reg <= capState_next;
            level_reg    <= level_next;
            sync1_reg    <= lockByte;
            sync2_reg    <= sync1_reg;
            sync3_reg    <= sync2_reg;
            syncFill_reg <= syncFill_next;
        end
    end

    // ==========================================================
    // access gating
    logic done;
    logic tableOk_next, fetchOk_next, progOk_next, verifyOk_next, ramOk_next;
    logic [7:0] sig_next;
    logic       sigV_next;
    logic tableOk_reg, fetchOk_reg, progOk_reg, verifyOk_reg, ramOk_reg;
    logic [7:0] sig_reg;
    logic       sigV_reg;

    assign done = (capState_reg == code_lock_pkg::CAP_DONE);

    always_comb begin
        tableOk_next  = tableReadReq && done &&
            !(tableReadFromExt && tableReadInt &&
              level_reg != code_lock_pkg::LVL_OPEN);
        progOk_next   = progReq && done &&
            level_reg == code_lock_pkg::LVL_OPEN;
        verifyOk_next = verifyReq && done &&
            (level_reg == code_lock_pkg::LVL_OPEN ||
             level_reg == code_lock_pkg::LVL_ONE);
        fetchOk_next  = extFetchReq && done &&
            level_reg != code_lock_pkg::LVL_THREE;
        ramOk_next    = ramExtReq && done &&
            level_reg != code_lock_pkg::LVL_THREE;
        sigV_next     = sigReq;
        case (sigIdx)
            code_lock_pkg::SIG_IDX_MAKER:  sig_next = code_lock_pkg::SIG_MAKER;
            code_lock_pkg::SIG_IDX_FAMILY:
                sig_next = code_lock_pkg::SIG_FAMILY;
            code_lock_pkg::SIG_IDX_PART:   sig_next = code_lock_pkg::SIG_PART;
            default:                       sig_next = 8'h00;
        endcase
        if (!sigReq)
            sig_next = 8'h00;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tableOk_reg  <= 1'b0;
            fetchOk_reg  <= 1'b0;
            progOk_reg   <= 1'b0;
            verifyOk_reg <= 1'b0;
            ramOk_reg    <= 1'b0;
            sig_reg      <= 8'h00;
            sigV_reg     <= 1'b0;
        end else begin
            tableOk_reg  <= tableOk_next;
            fetchOk_reg  <= fetchOk_next;
            progOk_reg   <= progOk_next;
            verifyOk_reg <= verifyOk_next;
            ramOk_reg    <= ramOk_next;
            sig_reg      <= sig_next;
            sigV_reg     <= sigV_next;
        end
    end

    logic levelValid_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            levelValid_reg <= 1'b0;
        else
            levelValid_reg <= done;
    end

    assign tableReadOk = tableOk_reg;
    assign extFetchOk  = fetchOk_reg;
    assign progOk      = progOk_reg;
    assign verifyOk    = verifyOk_reg;
    assign ramExtOk    = ramOk_reg;
    assign sigData     = sig_reg;
    assign sigValid    = sigV_reg;
    assign lockLevel   = level_reg;
    assign levelValid  = levelValid_reg;

    // ==========================================================
    // checks
    // capture takes several steps: stages filled and agreeing, then the
    // level is decoded, then the valid flag follows one edge later
    sequence s_capReady;
        capState_reg == code_lock_pkg::CAP_SETTLE && syncFill_reg[2] &&
            sync2_reg == sync3_reg;
    endsequence
    sequence s_capShown;
        done ##1 levelValid && $stable(lockLevel);
    endsequence

    a_prog_locked: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        level_reg != code_lock_pkg::LVL_OPEN |=> !progOk)
        else $error("programming granted while locked");
    a_open_prog: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        done && progReq && level_reg == code_lock_pkg::LVL_OPEN |=> progOk)
        else $error("programming refused while open");
    a_open_verify: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        done && verifyReq && level_reg == code_lock_pkg::LVL_OPEN
        |=> verifyOk)
        else $error("verify refused while open");
    a_table_block: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        tableReadFromExt && tableReadInt &&
        level_reg != code_lock_pkg::LVL_OPEN |=> !tableReadOk)
        else $error("external table read of internal code granted");
    a_table_local: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        done && tableReadReq && !tableReadFromExt |=> tableReadOk)
        else $error("table read from internal code refused");
    a_verify_lvl2: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        lockLevel[1] |=> !verifyOk)
        else $error("verify granted at level two or above");
    a_fetch_lvl3: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        level_reg == code_lock_pkg::LVL_THREE |=> !extFetchOk)
        else $error("external fetch granted at level three");
    a_fetch_open: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        done && extFetchReq && level_reg != code_lock_pkg::LVL_THREE
        |=> extFetchOk)
        else $error("external fetch refused below level three");
    a_ram_lvl3: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        level_reg == code_lock_pkg::LVL_THREE |=> !ramExtOk)
        else $error("ram access granted at level three");
    a_ram_open: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        done && ramExtReq && level_reg != code_lock_pkg::LVL_THREE
        |=> ramExtOk)
        else $error("ram access refused below level three");
    a_sig_answer: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        sigReq && sigIdx == code_lock_pkg::SIG_IDX_MAKER
        |=> sigValid && sigData == code_lock_pkg::SIG_MAKER)
        else $error("signature byte wrong");
    a_sig_idle: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !sigReq |=> !sigValid && sigData == 8'h00)
        else $error("signature shown without a request");
    a_level_held: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        done |=> done && $stable(level_reg))
        else $error("lock level changed after capture");
    a_early_grant: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !done |=> !(tableReadOk || extFetchOk || progOk || verifyOk ||
                    ramExtOk))
        else $error("access granted before the level was captured");
    a_early_capture: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !syncFill_reg[2] |=> !done)
        else $error("level captured before the pin was sampled");
    a_capture_seq: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_capReady |=> s_capShown)
        else $error("captured level not shown as valid");
endmodule

// file: tb/lock_programmer_model.sv
// programming system model that burns the lock byte for a chosen level
`timescale 1ns/1ps
module lock_programmer_model (
    input  wire logic [1:0] level,    // cumulative lock level 0..3
    output logic      [7:0] lockByte  // lock byte seen by the device
);
    // ==========================================================
    // one byte of the mask image; the lock byte sits after the user code
    // bits are only ever set in order, so no undefined mix is produced
    function automatic logic [7:0] imageByte(input logic [15:0] addr,
                                             input logic [1:0]  lvl);
        logic [7:0] b;
        b = 8'hFF;
        if (addr <= code_lock_pkg::CODE_TOP_ADDR) begin
            b = addr[7:0] ^ addr[15:8];
        end else if (addr == code_lock_pkg::LOCK_BYTE_ADDR) begin
            b[code_lock_pkg::LOCK_ONE_POS]   = !(lvl >= 2'h1);
            b[code_lock_pkg::LOCK_TWO_POS]   = !(lvl >= 2'h2);
            b[code_lock_pkg::LOCK_THREE_POS] = !(lvl == 2'h3);
        end
        return b;
    endfunction

    always_comb begin
        lockByte = imageByte(code_lock_pkg::LOCK_BYTE_ADDR, level);
    end
endmodule

// file: tb/code_memory_security_lock_tb.sv
// self-checking bench for the program memory lock block
`timescale 1ns/1ps
module code_memory_security_lock_tb;
    logic       coreClk, rstN, trReq, trExt, trInt, fetchReq, progReq;
    logic       verReq, ramReq, sigReq, trOk, fetchOk, progOk, verOk;
    logic       ramOk, sigValid, levelValid;
    logic [1:0] sigIdx, lockLevel, progLevel;
    logic [7:0] lockByte, sigData;
    int         badCount, checked;

    lock_programmer_model u_prog (.level(progLevel), .lockByte(lockByte));
    code_memory_security_lock u_dut (
        .core_clk(coreClk), .rst_n(rstN), .lockByte(lockByte),
        .tableReadReq(trReq), .tableReadFromExt(trExt),
        .tableReadInt(trInt), .extFetchReq(fetchReq), .progReq(progReq),
        .verifyReq(verReq), .ramExtReq(ramReq), .sigReq(sigReq),
        .sigIdx(sigIdx), .tableReadOk(trOk), .extFetchOk(fetchOk),
        .progOk(progOk), .verifyOk(verOk), .ramExtOk(ramOk),
        .sigData(sigData), .sigValid(sigValid), .lockLevel(lockLevel),
        .levelValid(levelValid));

    // ==========================================================
    // helpers
    task automatic step(input int n);
        repeat (n) @(posedge coreClk);
        #1;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask
    task automatic setReqs(input logic v);
        {trReq, trExt, trInt, fetchReq, progReq, verReq, ramReq} = {7{v}};
    endtask
    task automatic conclude;
        $display("mismatches %0d, comparisons %0d", badCount, checked);
        if (badCount == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    // requests held through reset: refused until the level is captured
    task automatic testLevel(input logic [1:0] lvl);
        int n;
        progLevel = lvl;
        setReqs(1'b1);
        rstN = 1'b0;
        step(2);
        rstN = 1'b1;
        step(1);
        check({7'h0, progOk}, 8'h00);
        check({3'h0, trOk, fetchOk, progOk, verOk, ramOk}, 8'h00);
        check({5'h0, levelValid, lockLevel}, 8'h03);
        // captured on the fourth edge after release, valid on the fifth
        for (n = 0; n < 20 && levelValid !== 1'b1; n++) step(1);
        check(8'(n), 8'h04);
        check({7'h0, levelValid}, 8'h01);
        check({6'h0, lockLevel}, {6'h0, lvl});
        step(1);
        check({7'h0, progOk}, {7'h0, lvl == 2'h0});
        check({7'h0, trOk}, {7'h0, lvl == 2'h0});
        check({7'h0, verOk}, {7'h0, lvl < 2'h2});
        check({7'h0, fetchOk}, {7'h0, lvl != 2'h3});
        check({7'h0, ramOk}, {7'h0, lvl != 2'h3});
        // only a read issued outside that targets internal code is blocked
        trExt = 1'b0;
        step(1);
        check({7'h0, trOk}, 8'h01);
        trExt = 1'b1;
        trInt = 1'b0;
        step(1);
        check({7'h0, trOk}, 8'h01);
        setReqs(1'b0);
        step(1);
        check({3'h0, trOk, fetchOk, progOk, verOk, ramOk}, 8'h00);
    endtask
    // a later change of the lock byte must not move the captured level
    task automatic testHold;
        progLevel = 2'h3;
        step(5);
        verReq = 1'b1;
        step(1);
        check({7'h0, verOk}, 8'h01);
        check({6'h0, lockLevel}, 8'h00);
        verReq = 1'b0;
    endtask
    task automatic testSig;
        logic [7:0] exp [4];
        exp = '{code_lock_pkg::SIG_MAKER, code_lock_pkg::SIG_FAMILY,
                code_lock_pkg::SIG_PART, 8'h00};
        sigReq = 1'b1;
        for (int i = 0; i < 4; i++) begin
            sigIdx = 2'(i);
            step(1);
            check(sigData, exp[i]);
            check({7'h0, sigValid}, 8'h01);
        end
        sigReq = 1'b0;
        step(1);
        check(sigData, 8'h00);
        check({7'h0, sigValid}, 8'h00);
    endtask

    initial begin
        coreClk = 1'b0;
        forever #2.5 coreClk = ~coreClk;
    end
    initial begin
        #20000;
        badCount++;
        conclude();
    end
    initial begin
        badCount = 0;
        checked = 0;
        rstN = 1'b0;
        progLevel = 2'h0;
        sigReq = 1'b0;
        sigIdx = 2'h0;
        setReqs(1'b0);
        for (int l = 3; l >= 0; l--) testLevel(2'(l));
        testHold();
        testSig();
        conclude();
    end
endmodule
